// ===== rtl/pcr_pkg.sv
package pcr_pkg;

   // ==========================================================
   // Register map
   localparam logic [15:0] PCR_ADDR_FAST_LOCK = 16'h010b;
   localparam logic [15:0] PCR_ADDR_PUMP_CUR  = 16'h0200;
   localparam logic [15:0] PCR_ADDR_FB_DIV    = 16'h0201;
   localparam logic [15:0] PCR_ADDR_CONTROL   = 16'h0202;
   localparam logic [15:0] PCR_ADDR_VCO_CTRL  = 16'h0203;

   // ==========================================================
   // Reset values and writable masks
   localparam logic [7:0]  PCR_RST_FAST_LOCK  = 8'h00;
   localparam logic [7:0]  PCR_RST_PUMP_CUR   = 8'h00;
   localparam logic [7:0]  PCR_RST_FB_DIV     = 8'h04;
   localparam logic [7:0]  PCR_RST_CONTROL    = 8'h03;
   localparam logic [7:0]  PCR_RST_VCO_CTRL   = 8'h00;
   localparam logic [7:0]  PCR_MASK_FULL      = 8'hff;
   localparam logic [7:0]  PCR_MASK_CONTROL   = 8'ha3;
   localparam logic [7:0]  PCR_MASK_VCO_CTRL  = 8'h1f;
   localparam logic [7:0]  PCR_RDATA_NONE     = 8'h00;

   // ==========================================================
   // Field positions
   localparam int          PCR_FL_EN_BIT      = 7;
   localparam int          PCR_CTL_LDPD_BIT   = 7;
   localparam int          PCR_CTL_DBL_BIT    = 5;
   localparam int          PCR_VCO_PATH_BIT   = 4;
   localparam int          PCR_VCO_DIVRST_BIT = 3;
   localparam int          PCR_VCO_VALID_BIT  = 2;
   localparam int          PCR_VCO_MID_BIT    = 1;
   localparam int          PCR_VCO_CAL_BIT    = 0;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      PCR_CP_TRISTATE = 2'b00,
      PCR_CP_DOWN     = 2'b01,
      PCR_CP_UP       = 2'b10,
      PCR_CP_NORMAL   = 2'b11
   } pcr_cp_mode_t;

   typedef struct packed {
      logic         fast_lock_en;
      logic [6:0]   fast_lock_cp_cur;
      logic [7:0]   loop2_cp_cur;
      logic [1:0]   fb_fine;
      logic [5:0]   fb_coarse;
      logic         lock_det_pd;
      logic         doubler_en;
      pcr_cp_mode_t cp_mode;
      logic         ref_path_en;
      logic         fb_div_reset;
      logic         ref_valid_force;
      logic         vco_midscale;
      logic         vco_cal;
   } pcr_cfg_t;

endpackage : pcr_pkg

// ===== rtl/pcr_reg8.sv
`timescale 1ns/1ps
module pcr_reg8 #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WR_MASK   = 8'hff
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   // Contents
   output logic [7:0]      q
);
   logic [7:0] q_d;

   // Reserved bits never store, so they read back as zero
   always_comb begin
      q_d = q;
      if (wr_en) begin
         q_d = wdata & WR_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RESET_VAL;
      end else begin
         q <= q_d;
      end
   end
endmodule : pcr_reg8

// ===== rtl/pcr_fb_div.sv
`timescale 1ns/1ps
module pcr_fb_div (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       hold,
   input  wire logic       tick_en,
   input  wire logic [5:0] coarse,
   input  wire logic [1:0] fine,
   // Divided output
   output logic            out_pulse_q,
   output logic [7:0]      count_q
);
   logic [7:0] count_d;
   logic       out_pulse_d;
   logic [7:0] last_val;

   // Division 4*coarse+fine; illegal small values are the host's problem
   assign last_val = {coarse, 2'b00} + {6'h00, fine} - 8'h01;

   always_comb begin
      count_d     = count_q;
      out_pulse_d = 1'b0;
      if (hold) begin
         count_d = 8'h00;
      end else if (tick_en) begin
         if (count_q >= last_val) begin
            count_d     = 8'h00;
            out_pulse_d = 1'b1;
         end else begin
            count_d = count_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q     <= 8'h00;
         out_pulse_q <= 1'b0;
      end else begin
         count_q     <= count_d;
         out_pulse_q <= out_pulse_d;
      end
   end
endmodule : pcr_fb_div

// ===== rtl/pcr_config_regs.sv
`timescale 1ns/1ps
module pcr_config_regs (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Register access from the serial control port
   input  wire logic [15:0]       reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata_q,
   output logic                   reg_rd_valid_q,
   output logic                   reg_addr_err_q,
   // Loop status inputs
   input  wire logic              osc_valid_pin,
   input  wire logic              vco_tick,
   // Configuration outputs
   output pcr_pkg::pcr_cfg_t      cfg,
   output logic                   ref_valid_q,
   output logic                   cal_start_q,
   output logic                   fb_div_pulse,
   output logic [7:0]             fb_div_count
);
   import pcr_pkg::*;

   // ==========================================================
   // Address decode
   logic       sel_fl;
   logic       sel_cp;
   logic       sel_fb;
   logic       sel_ctl;
   logic       sel_vco;
   logic       sel_none;
   logic [7:0] fl_q;
   logic [7:0] cp_q;
   logic [7:0] fb_q;
   logic [7:0] ctl_q;
   logic [7:0] vco_q;

   always_comb begin
      sel_fl   = 1'b0;
      sel_cp   = 1'b0;
      sel_fb   = 1'b0;
      sel_ctl  = 1'b0;
      sel_vco  = 1'b0;
      sel_none = 1'b0;
      if (reg_addr == PCR_ADDR_FAST_LOCK) begin
         sel_fl = 1'b1;
      end else if (reg_addr == PCR_ADDR_PUMP_CUR) begin
         sel_cp = 1'b1;
      end else if (reg_addr == PCR_ADDR_FB_DIV) begin
         sel_fb = 1'b1;
      end else if (reg_addr == PCR_ADDR_CONTROL) begin
         sel_ctl = 1'b1;
      end else if (reg_addr == PCR_ADDR_VCO_CTRL) begin
         sel_vco = 1'b1;
      end else begin
         sel_none = 1'b1;
      end
   end

   // ==========================================================
   // Register storage
   pcr_reg8 #(.RESET_VAL(PCR_RST_FAST_LOCK), .WR_MASK(PCR_MASK_FULL)) u_fl (
      .clk   (clk),
      .rst_n (rst_n),
      .wr_en (reg_wr && sel_fl),
      .wdata (reg_wdata),
      .q     (fl_q)
   );

   pcr_reg8 #(.RESET_VAL(PCR_RST_PUMP_CUR), .WR_MASK(PCR_MASK_FULL)) u_cp (
      .clk   (clk),
      .rst_n (rst_n),
      .wr_en (reg_wr && sel_cp),
      .wdata (reg_wdata),
      .q     (cp_q)
   );

   pcr_reg8 #(.RESET_VAL(PCR_RST_FB_DIV), .WR_MASK(PCR_MASK_FULL)) u_fb (
      .clk   (clk),
      .rst_n (rst_n),
      .wr_en (reg_wr && sel_fb),
      .wdata (reg_wdata),
      .q     (fb_q)
   );

   // Bit 6 is masked: a stray one from the host can never land
   pcr_reg8 #(.RESET_VAL(PCR_RST_CONTROL), .WR_MASK(PCR_MASK_CONTROL)) u_ctl (
      .clk   (clk),
      .rst_n (rst_n),
      .wr_en (reg_wr && sel_ctl),
      .wdata (reg_wdata),
      .q     (ctl_q)
   );

   pcr_reg8 #(.RESET_VAL(PCR_RST_VCO_CTRL), .WR_MASK(PCR_MASK_VCO_CTRL)) u_vco (
      .clk   (clk),
      .rst_n (rst_n),
      .wr_en (reg_wr && sel_vco),
      .wdata (reg_wdata),
      .q     (vco_q)
   );

   // ==========================================================
   // Field mapping
   always_comb begin
      cfg.fast_lock_en     = fl_q[PCR_FL_EN_BIT];
      cfg.fast_lock_cp_cur = fl_q[6:0];
      cfg.loop2_cp_cur     = cp_q;
      cfg.fb_fine          = fb_q[7:6];
      cfg.fb_coarse        = fb_q[5:0];
      cfg.lock_det_pd      = ctl_q[PCR_CTL_LDPD_BIT];
      cfg.doubler_en       = ctl_q[PCR_CTL_DBL_BIT];
      cfg.cp_mode          = pcr_cp_mode_t'(ctl_q[1:0]);
      cfg.ref_path_en      = vco_q[PCR_VCO_PATH_BIT];
      cfg.fb_div_reset     = vco_q[PCR_VCO_DIVRST_BIT];
      cfg.ref_valid_force  = vco_q[PCR_VCO_VALID_BIT];
      cfg.vco_midscale     = vco_q[PCR_VCO_MID_BIT];
      cfg.vco_cal          = vco_q[PCR_VCO_CAL_BIT];
   end

   // ==========================================================
   // Read port
   logic [7:0] rdata_d;
   logic       rd_valid_d;
   logic       addr_err_d;

   always_comb begin
      rdata_d    = reg_rdata_q;
      rd_valid_d = reg_rd;
      addr_err_d = (reg_rd || reg_wr) && sel_none;
      if (reg_rd) begin
         if (sel_fl) begin
            rdata_d = fl_q;
         end else if (sel_cp) begin
            rdata_d = cp_q;
         end else if (sel_fb) begin
            rdata_d = fb_q;
         end else if (sel_ctl) begin
            rdata_d = ctl_q;
         end else if (sel_vco) begin
            rdata_d = vco_q;
         end else begin
            rdata_d = PCR_RDATA_NONE;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_q    <= PCR_RDATA_NONE;
         reg_rd_valid_q <= 1'b0;
         reg_addr_err_q <= 1'b0;
      end else begin
         reg_rdata_q    <= rdata_d;
         reg_rd_valid_q <= rd_valid_d;
         reg_addr_err_q <= addr_err_d;
      end
   end

   // ==========================================================
   // Oscillator indicator and reference validity
   // Indicator is asynchronous; the third stage filters a single metastable sample
   logic [2:0] osc_sync_q;
   logic [2:0] osc_sync_d;
   logic       osc_stable_q;
   logic       osc_stable_d;
   logic       ref_valid_d;

   always_comb begin
      osc_sync_d   = {osc_sync_q[1:0], osc_valid_pin};
      osc_stable_d = osc_stable_q;
      if (osc_sync_q[1] == osc_sync_q[2]) begin
         osc_stable_d = osc_sync_q[2];
      end
      ref_valid_d = cfg.ref_valid_force || osc_stable_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_sync_q   <= 3'h0;
         osc_stable_q <= 1'b0;
         ref_valid_q  <= 1'b0;
      end else begin
         osc_sync_q   <= osc_sync_d;
         osc_stable_q <= osc_stable_d;
         ref_valid_q  <= ref_valid_d;
      end
   end

   // ==========================================================
   // Calibration start
   // Level stays with the host; only the rising edge is reported as a pulse
   logic cal_prev_q;
   logic cal_prev_d;
   logic cal_start_d;

   always_comb begin
      cal_prev_d  = cfg.vco_cal;
      cal_start_d = cfg.vco_cal && !cal_prev_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_prev_q  <= 1'b0;
         cal_start_q <= 1'b0;
      end else begin
         cal_prev_q  <= cal_prev_d;
         cal_start_q <= cal_start_d;
      end
   end

   // ==========================================================
   // Feedback divider
   pcr_fb_div u_fb_div (
      .clk         (clk),
      .rst_n       (rst_n),
      .hold        (cfg.fb_div_reset),
      .tick_en     (vco_tick),
      .coarse      (cfg.fb_coarse),
      .fine        (cfg.fb_fine),
      .out_pulse_q (fb_div_pulse),
      .count_q     (fb_div_count)
   );

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   fast_lock_en_a: assert property (reg_wr && sel_fl |=> cfg.fast_lock_en == $past(reg_wdata[7]))
      else $error("fast lock enable did not follow write");
   fl_current_a: assert property (reg_wr && sel_fl |=> cfg.fast_lock_cp_cur == $past(reg_wdata[6:0]))
      else $error("fast lock current did not follow write");
   pump_current_a: assert property (reg_wr && sel_cp ##1 !(reg_wr && sel_cp) |=>
      cfg.loop2_cp_cur == $past(reg_wdata, 2))
      else $error("pump current lost its written value");
   fb_words_a: assert property (reg_wr && sel_fb |=> {cfg.fb_fine, cfg.fb_coarse} == $past(reg_wdata))
      else $error("divider words did not follow write");
   lock_pd_a: assert property (reg_wr && sel_ctl |=> cfg.lock_det_pd == $past(reg_wdata[7]))
      else $error("lock detect power-down did not follow write");
   doubler_en_a: assert property (reg_wr && sel_ctl |=> cfg.doubler_en == $past(reg_wdata[5]) && !ctl_q[6])
      else $error("doubler enable wrong or reserved bit set");
   cp_mode_a: assert property (reg_wr && sel_ctl |=> cfg.cp_mode == pcr_cp_mode_t'($past(reg_wdata[1:0])))
      else $error("pump mode did not follow write");
   ref_path_a: assert property (reg_wr && sel_vco |=> cfg.ref_path_en == $past(reg_wdata[4]))
      else $error("reference path enable did not follow write");
   div_hold_a: assert property (cfg.fb_div_reset [*2] |-> fb_div_count == 8'h00 && !fb_div_pulse)
      else $error("divider ran while held in reset");
   ref_force_a: assert property (cfg.ref_valid_force |=> ref_valid_q)
      else $error("forced reference not reported valid");
   ref_follow_a: assert property (!cfg.ref_valid_force && !osc_stable_q |=> !ref_valid_q)
      else $error("reference valid without indicator");
   midscale_a: assert property (reg_wr && sel_vco |=> cfg.vco_midscale == $past(reg_wdata[1]))
      else $error("midscale force did not follow write");
   cal_sticky_a: assert property (cfg.vco_cal && !(reg_wr && sel_vco) |=> cfg.vco_cal)
      else $error("calibration bit cleared without host write");
   cal_pulse_a: assert property ($rose(cfg.vco_cal) |=> cal_start_q ##1 !cal_start_q)
      else $error("calibration start pulse wrong");
   readback_a: assert property (reg_rd && sel_cp && !reg_wr |=> reg_rd_valid_q && reg_rdata_q == cp_q)
      else $error("readback mismatch");

   // ==========================================================
   // Fields that follow writes or must hold, and the status outputs
   div_reset_a: assert property (reg_wr && sel_vco |=> cfg.fb_div_reset == $past(reg_wdata[3]))
      else $error("divider reset bit did not follow write");
   ref_force_wr_a: assert property (reg_wr && sel_vco |=> cfg.ref_valid_force == $past(reg_wdata[2]))
      else $error("reference force bit did not follow write");
   cal_write_a: assert property (reg_wr && sel_vco |=> cfg.vco_cal == $past(reg_wdata[0]))
      else $error("calibration bit did not follow write");
   cfg_hold_a: assert property (!reg_wr |=> $stable(cfg))
      else $error("a field changed without a write");
   unmapped_wr_a: assert property (reg_wr && sel_none |=> $stable(cfg))
      else $error("unmapped write changed a field");
   ref_rise_a: assert property (!cfg.ref_valid_force && osc_stable_q |=> ref_valid_q)
      else $error("stable indicator not reported valid");
   cal_origin_a: assert property (cal_start_q |-> $past(cfg.vco_cal) && !$past(cfg.vco_cal, 2))
      else $error("calibration pulse without a rising bit");

   cal_single_a: assert property (cal_start_q |=> !cal_start_q)
      else $error("calibration pulse longer than one cycle");
   div_stall_a: assert property (!cfg.fb_div_reset && !vco_tick |=>
      $stable(fb_div_count) && !fb_div_pulse)
      else $error("divider moved without a tick");
   div_pulse_a: assert property (fb_div_pulse |-> fb_div_count == 8'h00)
      else $error("divider pulse away from the wrap");
   hold_release_a: assert property ($fell(cfg.fb_div_reset) |-> fb_div_count == 8'h00)
      else $error("divider not cleared at release");
   rd_valid_a: assert property (reg_rd_valid_q == $past(reg_rd))
      else $error("read valid not one cycle after read");
   err_pulse_a: assert property (reg_addr_err_q == $past((reg_rd || reg_wr) && sel_none))
      else $error("address error pulse wrong");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
      else $error("read data moved without a read");
   unmapped_rd_a: assert property (reg_rd && sel_none |=> reg_rdata_q == PCR_RDATA_NONE)
      else $error("unmapped read returned data");

   // ==========================================================
   // Coverage
   hold_cover_c: cover property (cfg.fb_div_reset && vco_tick);
   cal_cover_c: cover property ($rose(cfg.vco_cal) ##[1:20] $fell(cfg.vco_cal));
   div_cover_c: cover property (fb_div_pulse ##[1:300] fb_div_pulse);
   force_cover_c: cover property (!osc_stable_q && ref_valid_q);
   unmapped_cover_c: cover property (reg_addr_err_q);

endmodule : pcr_config_regs

// ===== verification/pcr_config_regs_test.sv
`timescale 1ns/1ps
module pcr_config_regs_test;
   import pcr_pkg::*;

   // ==========================================================
   // Signals
   logic        clk;
   logic        rst_n;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata_q;
   logic        reg_rd_valid_q;
   logic        reg_addr_err_q;
   logic        osc_valid_pin;
   logic        vco_tick;
   pcr_cfg_t    cfg;
   logic        ref_valid_q;
   logic        cal_start_q;
   logic        fb_div_pulse;
   logic [7:0]  fb_div_count;
   int          err_total;
   int          n_tests;
   int          cyc;
   int          per;
   logic [31:0] lfsr_q;
   logic [7:0]  mdl [5];
   logic [15:0] adr [5] = '{PCR_ADDR_FAST_LOCK, PCR_ADDR_PUMP_CUR, PCR_ADDR_FB_DIV,
                            PCR_ADDR_CONTROL, PCR_ADDR_VCO_CTRL};
   logic [7:0]  msk [5] = '{PCR_MASK_FULL, PCR_MASK_FULL, PCR_MASK_FULL, PCR_MASK_CONTROL, PCR_MASK_VCO_CTRL};
   logic [7:0]  rst [5] = '{PCR_RST_FAST_LOCK, PCR_RST_PUMP_CUR, PCR_RST_FB_DIV, PCR_RST_CONTROL, PCR_RST_VCO_CTRL};
   logic [7:0]  fbw [5] = '{8'h04, 8'h44, 8'h85, 8'hc7, 8'hff};

   pcr_config_regs u_pcr_config_regs (
      .clk            (clk),
      .rst_n          (rst_n),
      .reg_addr       (reg_addr),
      .reg_wdata      (reg_wdata),
      .reg_wr         (reg_wr),
      .reg_rd         (reg_rd),
      .reg_rdata_q    (reg_rdata_q),
      .reg_rd_valid_q (reg_rd_valid_q),
      .reg_addr_err_q (reg_addr_err_q),
      .osc_valid_pin  (osc_valid_pin),
      .vco_tick       (vco_tick),
      .cfg            (cfg),
      .ref_valid_q    (ref_valid_q),
      .cal_start_q    (cal_start_q),
      .fb_div_pulse   (fb_div_pulse),
      .fb_div_count   (fb_div_count)
   );

   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr_next(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next

   function automatic int idx_of(logic [15:0] a);
      for (int k = 0; k < 5; k++) begin
         if (adr[k] == a) begin
            return k;
         end
      end
      return -1;
   endfunction : idx_of

   // Expected field layout, rebuilt from the model bytes
   function logic [32:0] exp_cfg();
      return {mdl[0], mdl[1], mdl[2], mdl[3][7], mdl[3][5], mdl[3][1:0], mdl[4][4:0]};
   endfunction : exp_cfg

   task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(logic [15:0] a, logic [7:0] d);
      int i;
      i = idx_of(a);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
      // Reserved bits never store, so they read back as zero
      if (i >= 0) mdl[i] = d & msk[i];
      #1;
      chk("cfg", {31'h0, exp_cfg()}, {31'h0, cfg});
      chk("wr_addr_err", {63'h0, i < 0}, {63'h0, reg_addr_err_q});
      chk("wr_rd_valid", 64'h0, {63'h0, reg_rd_valid_q});
   endtask : wr

   task automatic rd(logic [15:0] a);
      int i;
      i = idx_of(a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      chk("rd_valid", 64'h1, {63'h0, reg_rd_valid_q});
      chk("rdata", {56'h0, (i < 0) ? PCR_RDATA_NONE : mdl[i]}, {56'h0, reg_rdata_q});
      chk("rd_addr_err", {63'h0, i < 0}, {63'h0, reg_addr_err_q});
   endtask : rd

   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // Period between two divider pulses; bounded so a dead counter cannot hang
   task automatic measure(output int n);
      int t;
      t = 0;
      while (fb_div_pulse !== 1'b1 && t < 600) begin
         tick(1);
         t++;
      end
      t = 0;
      do begin
         tick(1);
         t++;
      end while (fb_div_pulse !== 1'b1 && t < 600);
      n = t;
   endtask : measure

   task automatic tally_and_finish();
      $display("mismatches %0d, comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   // ==========================================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      reg_addr = 16'h0;
      reg_wdata = 8'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      osc_valid_pin = 1'b0;
      vco_tick = 1'b0;
      err_total = 0;
      n_tests = 0;
      cyc = 0;
      lfsr_q = 32'h7453a1cc;
      for (int k = 0; k < 5; k++) mdl[k] = rst[k];
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 5; k++) rd(adr[k]);
      chk("cfg_rst", {31'h0, exp_cfg()}, {31'h0, cfg});
      for (int m = 0; m < 4; m++) begin
         wr(PCR_ADDR_CONTROL, 8'(m));
         chk("cp_mode", 64'(m), {62'h0, cfg.cp_mode});
      end
      // Host keeps control bit 6 at zero
      for (int b = 0; b < 8; b++) begin
         wr(PCR_ADDR_CONTROL, 8'(1 << b) & 8'hbf);
         wr(PCR_ADDR_VCO_CTRL, 8'(1 << b));
         rd(PCR_ADDR_VCO_CTRL);
      end
      // Random traffic over mapped and unmapped places, legal divider pairs only
      repeat (40) begin
         int k;
         logic [15:0] a;
         logic [7:0]  d;
         lfsr_q = lfsr_next(lfsr_q);
         k = int'(lfsr_q[26:24]) % 6;
         a = (k == 5) ? {8'h03, lfsr_q[15:8]} : adr[k];
         d = lfsr_q[7:0];
         if (k == 3) d[6] = 1'b0;
         if (k == 2) d = {lfsr_q[1:0], 6'(7 + int'(lfsr_q[7:2]) % 57)};
         wr(a, d);
         rd(a);
      end
      // Calibration start: one-cycle pulse, level kept until the host clears it
      wr(PCR_ADDR_VCO_CTRL, 8'h00);
      wr(PCR_ADDR_VCO_CTRL, 8'h01);
      chk("cal_c1", 64'h0, {63'h0, cal_start_q});
      tick(1);
      chk("cal_c2", 64'h1, {63'h0, cal_start_q});
      tick(1);
      chk("cal_c3", 64'h0, {63'h0, cal_start_q});
      tick(50);
      chk("cal_level", 64'h1, {63'h0, cfg.vco_cal});
      wr(PCR_ADDR_VCO_CTRL, 8'h00);
      // Reference validity follows the indicator unless forced
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         osc_valid_pin <= p[0];
         tick(8);
         chk("ref_follow", 64'(p), {63'h0, ref_valid_q});
      end
      @(posedge clk);
      osc_valid_pin <= 1'b0;
      wr(PCR_ADDR_VCO_CTRL, 8'h04);
      tick(1);
      chk("ref_force", 64'h1, {63'h0, ref_valid_q});
      tick(8);
      chk("ref_force_hold", 64'h1, {63'h0, ref_valid_q});
      // Divider held, then periods for boundary word pairs
      @(posedge clk);
      vco_tick <= 1'b1;
      wr(PCR_ADDR_VCO_CTRL, 8'h08);
      repeat (20) begin
         tick(1);
         chk("hold_count", 64'h0, {56'h0, fb_div_count});
         chk("hold_pulse", 64'h0, {63'h0, fb_div_pulse});
      end
      foreach (fbw[j]) begin
         wr(PCR_ADDR_VCO_CTRL, 8'h08);
         wr(PCR_ADDR_FB_DIV, fbw[j]);
         wr(PCR_ADDR_VCO_CTRL, 8'h00);
         measure(per);
         chk("fb_period", 64'(4 * int'(fbw[j][5:0]) + int'(fbw[j][7:6])), 64'(per));
      end
      tally_and_finish();
   end

endmodule : pcr_config_regs_test
